/* rtl/sar_pkg.sv */
// Shared constants and types of the sampling converter readout block.
// Assumes one core clock of SAR_CLK_PERIOD_NS and a host serial clock of its own.
`default_nettype none

package sar_pkg;

   // ==========================================================================
   // Result word and timing
   // ==========================================================================
   localparam int          SAR_RESULT_W      = 16;
   localparam int          SAR_FALL_W        = 6;
   localparam int          SAR_CLK_PERIOD_NS = 50;
   localparam int          SAR_CONV_TIME_NS  = 500;
   // Conversion duration rounded up to whole core cycles, never below one.
   localparam int          SAR_CONV_CYCLES   =
      ((SAR_CONV_TIME_NS + SAR_CLK_PERIOD_NS - 1) / SAR_CLK_PERIOD_NS) < 1 ? 1 :
      ((SAR_CONV_TIME_NS + SAR_CLK_PERIOD_NS - 1) / SAR_CLK_PERIOD_NS);
   localparam logic [SAR_RESULT_W-1:0] SAR_CODE_MAX  = 16'hFFFF;
   localparam logic [SAR_RESULT_W-1:0] SAR_CODE_MIN  = 16'h0000;
   localparam logic [SAR_FALL_W-1:0]   SAR_FALLS_FULL = 6'h10;
   localparam logic [SAR_FALL_W-1:0]   SAR_FALLS_ZERO = 6'h00;

   // ==========================================================================
   // Types
   // ==========================================================================
   typedef enum logic {SAR_MODE_SELECT, SAR_MODE_CHAIN} sar_mode_t;
   typedef enum logic [1:0] {SAR_IDLE, SAR_CONVERT, SAR_ACQUIRE} sar_phase_t;

   // Front-end comparator result with range flags.
   typedef struct packed {
      logic [SAR_RESULT_W-1:0] code;
      logic                    over;
      logic                    under;
   } sar_sample_t;

endpackage : sar_pkg

`default_nettype wire

/* rtl/sar_sync.sv */
// Three-stage synchroniser for levels and gray words from another clock.
// Assumes each bit changes at most once per settle window (levels or gray).
`default_nettype none

module sar_sync
   import sar_pkg::*;
#(
   parameter int             W    = 1,
   parameter logic [W-1:0]   INIT = '0
)
(
   input  wire logic          clk_i,
   input  wire logic          reset_n_i,
   input  wire logic [W-1:0]  async_i,
   output logic      [W-1:0]  sync_o
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] out;
   } sar_sync_state_t;

   sar_sync_state_t st_q;
   sar_sync_state_t st_d;

   // ==========================================================================
   // Chain and agreement filter
   // ==========================================================================
   // A change is taken only once stages two and three agree, so a bit that
   // went metastable in stage one never reaches the output directly.
   always_comb
   begin
      st_d    = st_q;
      st_d.s1 = async_i;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < W; i++)
      begin
         if (st_q.s2[i] == st_q.s3[i])
         begin
            st_d.out[i] = st_q.s3[i];
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         st_q <= '{s1: INIT, s2: INIT, s3: INIT, out: INIT};
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign sync_o = st_q.out;

endmodule : sar_sync

`default_nettype wire

/* rtl/sar_link.sv */
// Serial-clock side of the readout: output shift register and fall counter.
// Assumes the host keeps its serial clock quiet while a result is published.
`default_nettype none

module sar_link
   import sar_pkg::*;
(
   input  wire logic                    sck_i,
   input  wire logic                    reset_n_i,
   input  wire logic                    serial_input_pin_i,
   input  wire logic [SAR_RESULT_W-1:0] word_i,
   input  wire logic                    load_tgl_i,
   output logic                         shift_msb_o,
   output logic                         seen_tgl_o,
   output logic      [SAR_FALL_W-1:0]   fall_gray_o
);

   typedef struct packed {
      logic [SAR_RESULT_W-1:0] shreg;
      logic                    seen;
      logic [SAR_FALL_W-1:0]   falls;
      logic [SAR_FALL_W-1:0]   gray;
   } sar_link_state_t;

   sar_link_state_t st_q;
   sar_link_state_t st_d;
   logic [SAR_FALL_W-1:0] falls_next;

   // ==========================================================================
   // Falling-edge shifter
   // ==========================================================================
   // The word and its toggle are static long before the host clocks again,
   // so they are taken directly; a fresh toggle makes this edge load-and-shift.
   always_comb
   begin
      st_d       = st_q;
      falls_next = st_q.falls + 1'b1;
      if (load_tgl_i != st_q.seen)
      begin
         st_d.shreg = {word_i[SAR_RESULT_W-2:0], serial_input_pin_i}; // R23 R18
         st_d.seen  = load_tgl_i;
      end
      else
      begin
         st_d.shreg = {st_q.shreg[SAR_RESULT_W-2:0], serial_input_pin_i}; // R8 R18
      end
      st_d.falls = falls_next;
      st_d.gray  = falls_next ^ (falls_next >> 1);
   end

   always_ff @(negedge sck_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign shift_msb_o = st_q.shreg[SAR_RESULT_W-1];
   assign seen_tgl_o  = st_q.seen;
   assign fall_gray_o = st_q.gray;

endmodule : sar_link

`default_nettype wire

/* rtl/sar_readout.sv */
// Conversion-start, mode capture and serial readout of a 16-bit converter.
// Assumes pins arrive raw; the core clock times conversions, the host clocks data.
// The host serial clock must stand still around the end of a conversion, because
// the result word enters the link domain without a synchroniser of its own.
//
// Functional notes
// R1: Serial input level at each conversion-start rise picks the mode.
// R2: High input selects chip-select mode; low selects daisy-chain mode.
// R3: Input tied to conversion-start yields daisy-chain, via pre-edge hold.
// R4: Host waits the maximum conversion time before reading.
// R5: 3-wire: conversion-start rise begins conversion and floats the output.
// R6: Conversion end enters acquisition and powers down unprompted.
// R7: 3-wire: conversion-start falling drives the result MSB.
// R8: Later bits shift on serial clock falls, valid on both edges.
// R9: 3-wire: output floats at 16th fall or conversion-start rise.
// R10: 4-wire: host keeps conversion-start high through conversion and read.
// R11: Serial input and conversion-start both low drive the output low.
// R12: 4-wire: host returns serial input high within conversion time limits.
// R13: 4-wire: serial input falling starts the read with the MSB.
// R14: 4-wire: output floats at 16th fall or serial input rise.
// R15: Chain: host holds serial clock low at conversion-start rise.
// R16: Chain: host holds conversion-start high through conversion and read.
// R17: Chain: MSB appears at conversion end without any host edge.
// R18: Chain: serial input shifts into the result register on falls.
// R19: Host supplies sixteen clocks per chained device, MSB first.
// R20: Host may capture on either serial clock edge.
// R21: An internal clock times the conversion; serial clock not needed.
// R22: Result is straight binary, saturating at all-zero and all-one.
// R23: Full result is loaded into the shift register before bit one.
`default_nettype none

module sar_readout
   import sar_pkg::*;
#(
   parameter int CONV_CYCLES = SAR_CONV_CYCLES
)
(
   input  wire logic        core_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        sck_i,
   input  wire logic        conversion_start_pin_i,
   input  wire logic        serial_input_pin_i,
   input  wire sar_sample_t sample_i,
   output logic             serial_output_pin_o,
   output logic             serial_output_pin_oe_o,
   output logic             conversion_busy_o,
   output logic             powered_down_o,
   output logic             chain_mode_o
);

   typedef struct packed {
      sar_phase_t              phase;
      sar_mode_t               mode;
      logic [15:0]             timer;
      logic [SAR_RESULT_W-1:0] held;
      logic [SAR_RESULT_W-1:0] word;
      logic                    load_tgl;
      logic [SAR_FALL_W-1:0]   base;
      logic                    reading;
      logic                    read_done;
      logic                    four_wire;
      logic                    oe;
      logic                    force_low;
      logic                    busy;
      logic                    pwrdn;
      logic                    cnv_prev;
      logic                    sdi_prev;
   } sar_core_state_t;

   sar_core_state_t       st_q;
   sar_core_state_t       st_d;
   logic [1:0]            pins_s;
   logic                  cnv_s;
   logic                  sdi_s;
   logic [SAR_FALL_W-1:0] fall_gray_s;
   logic [SAR_FALL_W-1:0] falls_bin;
   logic [SAR_FALL_W-1:0] falls_rel;
   logic                  shift_msb;
   logic                  seen_tgl;
   logic                  seen_tgl_s;
   logic [SAR_FALL_W-1:0] fall_gray_s_raw;
   logic                  cnv_rise;
   logic                  start3;
   logic                  start4;

   // ==========================================================================
   // Crossings
   // ==========================================================================
   // Pins and the fall count come from outside the core clock domain.
   sar_sync #(.W(2), .INIT(2'h0)) u_pin_sync
   (
      .clk_i     (core_clk_i),
      .reset_n_i (reset_n_i),
      .async_i   ({conversion_start_pin_i, serial_input_pin_i}),
      .sync_o    (pins_s)
   );

   sar_sync #(.W(SAR_FALL_W), .INIT(6'h00)) u_fall_sync
   (
      .clk_i     (core_clk_i),
      .reset_n_i (reset_n_i),
      .async_i   (fall_gray_s_raw),
      .sync_o    (fall_gray_s)
   );

   sar_link u_link
   (
      .sck_i              (sck_i),
      .reset_n_i          (reset_n_i),
      .serial_input_pin_i (serial_input_pin_i),
      .word_i             (st_q.word),
      .load_tgl_i         (st_q.load_tgl),
      .shift_msb_o        (shift_msb),
      .seen_tgl_o         (seen_tgl),
      .fall_gray_o        (fall_gray_s_raw)
   );

   // The link's load acknowledge. It is only looked at when a conversion ends,
   // long after the last fall, so the synchroniser delay costs nothing there.
   sar_sync #(.W(1), .INIT(1'b0)) u_seen_sync
   (
      .clk_i     (core_clk_i),
      .reset_n_i (reset_n_i),
      .async_i   (seen_tgl),
      .sync_o    (seen_tgl_s)
   );

   assign cnv_s = pins_s[1];
   assign sdi_s = pins_s[0];

   // Gray to binary so the core can count falls since the read began.
   always_comb
   begin
      falls_bin[SAR_FALL_W-1] = fall_gray_s[SAR_FALL_W-1];
      for (int i = SAR_FALL_W - 2; i >= 0; i--)
      begin
         falls_bin[i] = falls_bin[i+1] ^ fall_gray_s[i];
      end
   end

   // ==========================================================================
   // Sequencer
   // ==========================================================================
   assign cnv_rise  = cnv_s & ~st_q.cnv_prev;
   assign falls_rel = falls_bin - st_q.base;
   assign start3    = ~cnv_s; // R7
   assign start4    = cnv_s & ~sdi_s; // R13

   // The mode uses the input level held from before the edge, so an input
   // wired to conversion-start still reads low and picks the chain.
   always_comb
   begin
      st_d          = st_q;
      st_d.cnv_prev = cnv_s;
      st_d.sdi_prev = sdi_s;
      if (cnv_rise)
      begin
         st_d.phase     = SAR_CONVERT;
         st_d.mode      = st_q.sdi_prev ? SAR_MODE_SELECT : SAR_MODE_CHAIN; // R1 R2 R3
         st_d.timer     = '0;
         st_d.oe        = 1'b0; // R5 R9
         st_d.reading   = 1'b0;
         st_d.read_done = 1'b0;
         st_d.busy      = 1'b1;
         st_d.pwrdn     = 1'b0;
         if (sample_i.over)
         begin
            st_d.held = SAR_CODE_MAX; // R22
         end
         else if (sample_i.under)
         begin
            st_d.held = SAR_CODE_MIN; // R22
         end
         else
         begin
            st_d.held = sample_i.code;
         end
      end
      else
      begin
         case (st_q.phase)
            SAR_CONVERT:
            begin
               // Timed on the core clock only; the serial clock may stand still.
               st_d.timer = st_q.timer + 16'h0001; // R21
               if (st_q.timer == 16'(CONV_CYCLES - 1))
               begin
                  st_d.phase    = SAR_ACQUIRE; // R6
                  st_d.busy     = 1'b0;
                  st_d.pwrdn    = 1'b1; // R6
                  st_d.word     = st_q.held; // R23
                  // A load the link has not taken yet stays pending with the new
                  // word; toggling again would cancel it and expose stale bits.
                  if (seen_tgl_s == st_q.load_tgl)
                  begin
                     st_d.load_tgl = ~st_q.load_tgl; // R23
                  end
                  st_d.base     = falls_bin;
                  if (st_q.mode == SAR_MODE_CHAIN)
                  begin
                     st_d.oe      = 1'b1; // R17
                     st_d.reading = 1'b1;
                  end
               end
            end
            SAR_ACQUIRE:
            begin
               if (st_q.mode == SAR_MODE_SELECT)
               begin
                  if (!st_q.reading && !st_q.read_done && (start3 || start4))
                  begin
                     st_d.reading   = 1'b1;
                     st_d.four_wire = cnv_s;
                     st_d.oe        = 1'b1; // R7 R13
                     st_d.base      = falls_bin;
                  end
                  else if (st_q.reading &&
                           ((falls_rel >= SAR_FALLS_FULL) || (st_q.four_wire && sdi_s)))
                  begin
                     st_d.reading   = 1'b0; // R9 R14
                     st_d.read_done = 1'b1;
                     st_d.oe        = 1'b0;
                  end
               end
            end
            default:
            begin
               st_d.phase = SAR_IDLE;
            end
         endcase
      end
      // Both pins low pull the line low in every mode, a chain read included,
      // so a host that parks both pins low always sees a defined level.
      st_d.force_low = ~cnv_s & ~sdi_s; // R11
      if (st_d.force_low)
      begin
         st_d.oe = 1'b1; // R11
      end
      else if (!st_d.reading)
      begin
         st_d.oe = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         st_q <= '{phase: SAR_IDLE, mode: SAR_MODE_SELECT, default: '0};
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ==========================================================================
   // Pin drive
   // ==========================================================================
   // Before the first fall of a read the MSB comes straight from the word,
   // so no host edge is needed; afterwards the link register owns the bit.
   // Data and toggles are flops; only the toggle compare and this final three-way pick are gated.
   assign serial_output_pin_o    = st_q.force_low ? 1'b0 :
                                   (seen_tgl == st_q.load_tgl) ? shift_msb :
                                   st_q.word[SAR_RESULT_W-1]; // R7 R8 R17
   assign serial_output_pin_oe_o = st_q.oe;
   assign conversion_busy_o      = st_q.busy;
   assign powered_down_o         = st_q.pwrdn;
   assign chain_mode_o           = (st_q.mode == SAR_MODE_CHAIN);

endmodule : sar_readout

`default_nettype wire

/* tb/sar_readout_properties.sv */
// Concurrent checks on the ports of the converter readout block.
// Assumes it is bound to the design and sees the raw pins on the core clock.
`default_nettype none

module sar_readout_properties
   import sar_pkg::*;
#(
   parameter int CONV_CYCLES = 10
)
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic conversion_start_pin_i,
   input wire logic serial_input_pin_i,
   input wire logic serial_output_pin_o,
   input wire logic serial_output_pin_oe_o,
   input wire logic conversion_busy_o,
   input wire logic powered_down_o,
   input wire logic chain_mode_o
);
   // =======================================================================
   // Helper logic and assertions
   // =======================================================================
   logic [7:0] busy_len_q;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   // Counts each busy stretch, because repetition counts cannot take a parameter.
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         busy_len_q <= 8'h00;
      else if (conversion_busy_o)
         busy_len_q <= busy_len_q + 8'h01;
      else
         busy_len_q <= 8'h00;
   end

   a_busy_span : assert property (
      $fell(conversion_busy_o) |-> busy_len_q == 8'(CONV_CYCLES))
      else $error("conversion length wrong");
   a_busy_floats : assert property (
      conversion_busy_o |-> !serial_output_pin_oe_o)
      else $error("line driven while converting");
   a_done_sleeps : assert property (
      $fell(conversion_busy_o) |-> powered_down_o)
      else $error("no power down after conversion");
   a_start_frees : assert property (
      $rose(conversion_start_pin_i) |->
         ##[2:6] (conversion_busy_o && !serial_output_pin_oe_o))
      else $error("start rise did not restart and float");
   a_fall_drives : assert property (
      $fell(conversion_start_pin_i) && serial_input_pin_i && powered_down_o
         && !chain_mode_o |-> ##[2:6] serial_output_pin_oe_o)
      else $error("start fall did not drive the line");
   a_select_drives : assert property (
      $fell(serial_input_pin_i) && conversion_start_pin_i && powered_down_o
         && !chain_mode_o |-> ##[2:6] serial_output_pin_oe_o)
      else $error("select low did not drive the line");
   a_deselect_frees : assert property (
      $rose(serial_input_pin_i) && conversion_start_pin_i && !chain_mode_o
         |-> ##[2:6] !serial_output_pin_oe_o)
      else $error("select high did not float the line");
   a_low_pins_low : assert property (
      (!conversion_start_pin_i && !serial_input_pin_i && !conversion_busy_o) [*8]
         |-> serial_output_pin_oe_o && !serial_output_pin_o)
      else $error("line not driven low");
   a_chain_unclocked : assert property (
      $fell(conversion_busy_o) && chain_mode_o |-> ##[0:2] serial_output_pin_oe_o)
      else $error("chain result not presented");

   c_three_wire : cover property ($fell(conversion_start_pin_i) && powered_down_o);
   c_four_wire : cover property ($fell(serial_input_pin_i) && conversion_start_pin_i);
   c_chain_done : cover property ($fell(conversion_busy_o) && chain_mode_o);

endmodule : sar_readout_properties

`default_nettype wire

/* tb/sar_host.sv */
// Host model: drives start, select and serial clock pins and reads data.
// Assumes the bench calls its tasks from one process at a time.
`default_nettype none

module sar_host
(
   input  wire logic core_clk_i,
   input  wire logic serial_output_pin_i,
   input  wire logic serial_output_pin_oe_i,
   output var  logic sck_o,
   output var  logic conversion_start_pin_o,
   output var  logic serial_input_pin_o,
   output logic      line_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // =======================================================================
   // Line model and pin tasks
   // =======================================================================
   logic last_q = 1'b0;

   // A released line shows the inverse of its last value, so floating reads fail.
   always @(posedge core_clk_i)
   begin
      if (serial_output_pin_oe_i)
         last_q <= serial_output_pin_i;
   end
   assign line_o = serial_output_pin_oe_i ? serial_output_pin_i : ~last_q;

   // Clock parked low outside frames; select strapped high at power-up.
   initial
   begin
      sck_o = 1'b0;
      conversion_start_pin_o = 1'b0;
      serial_input_pin_o = 1'b1;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : cyc

   task automatic set_pins(input logic start, input logic sel);
      cyc(1);
      conversion_start_pin_o = start;
      serial_input_pin_o = sel;
   endtask : set_pins

   // Sixteen 80 ns clocks; bits are taken at the rising edge, feed is set before it.
   task automatic shift16(input logic [15:0] feed, output logic [15:0] got);
      for (int i = 15; i >= 0; i--)
      begin
         serial_input_pin_o = feed[i];
         #13 sck_o = 1'b1;
         got[i] = line_o;
         #40 sck_o = 1'b0;
         #27;
      end
   endtask : shift16

endmodule : sar_host

`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench of the converter readout block.
// Assumes the host model owns the pins and the checker is bound to the design.
`default_nettype none

module tb_top
   import sar_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   // =======================================================================
   // Signals, design and host
   // =======================================================================
   logic        core_clk;
   logic        reset_n;
   logic        sck;
   logic        conv_pin;
   logic        din_pin;
   logic        dout_pin;
   logic        dout_oe;
   logic        busy;
   logic        pdown;
   logic        chain;
   logic        line;
   sar_sample_t sample;
   logic [15:0] got;
   int          bad_count;
   int          tests_run;

   // Core clock of 50 ns.
   initial core_clk = 1'b0;
   always #25 core_clk = ~core_clk;

   sar_readout DUT
   (
      .core_clk_i             (core_clk),
      .reset_n_i              (reset_n),
      .sck_i                  (sck),
      .conversion_start_pin_i (conv_pin),
      .serial_input_pin_i     (din_pin),
      .sample_i               (sample),
      .serial_output_pin_o    (dout_pin),
      .serial_output_pin_oe_o (dout_oe),
      .conversion_busy_o      (busy),
      .powered_down_o         (pdown),
      .chain_mode_o           (chain)
   );

   sar_host u_host
   (
      .core_clk_i             (core_clk),
      .serial_output_pin_i    (dout_pin),
      .serial_output_pin_oe_i (dout_oe),
      .sck_o                  (sck),
      .conversion_start_pin_o (conv_pin),
      .serial_input_pin_o     (din_pin),
      .line_o                 (line)
   );

   // =======================================================================
   // Tasks
   // =======================================================================
   task automatic chk(input logic ok, input string what);
      tests_run++;
      if (ok !== 1'b1)
      begin
         bad_count++;
         $display("BAD %0t %s", $time, what);
      end
   endtask : chk

   task automatic start(input logic [15:0] code, input logic ovr, input logic und,
                        input logic sel);
      sample = '{code: code, over: ovr, under: und};
      u_host.set_pins(1'b1, sel);
   endtask : start

   task automatic t_three_wire();
      start(16'hB4E1, 1'b0, 1'b0, 1'b1);
      u_host.cyc(8);
      chk(busy === 1'b1 && dout_oe === 1'b0, "start floats line");
      u_host.cyc(22);
      chk(busy === 1'b0 && pdown === 1'b1, "power down");
      chk(chain === 1'b0, "select mode");
      u_host.set_pins(1'b0, 1'b1);
      u_host.cyc(8);
      chk(dout_oe === 1'b1 && line === 1'b1, "msb on start fall");
      u_host.shift16(16'hFFFF, got);
      chk(got === 16'hB4E1, "three-wire word");
      u_host.cyc(8);
      chk(dout_oe === 1'b0, "float after 16 falls");
      $display("three_wire done");
   endtask : t_three_wire

   // A fresh start in mid-read must end the read at once.
   task automatic t_abort();
      start(16'h1234, 1'b1, 1'b0, 1'b1);
      u_host.cyc(30);
      u_host.set_pins(1'b0, 1'b1);
      u_host.cyc(8);
      chk(dout_oe === 1'b1 && line === 1'b1, "over-range saturates");
      u_host.set_pins(1'b1, 1'b1);
      u_host.cyc(8);
      chk(dout_oe === 1'b0 && busy === 1'b1, "start rise ends read");
      u_host.cyc(22);
      $display("abort done");
   endtask : t_abort

   task automatic t_four_wire();
      u_host.set_pins(1'b0, 1'b1);
      u_host.cyc(8);
      start(16'hA5C3, 1'b0, 1'b1, 1'b1);
      u_host.cyc(30);
      u_host.set_pins(1'b1, 1'b0);
      u_host.cyc(8);
      chk(dout_oe === 1'b1 && line === 1'b0, "select drives msb");
      u_host.set_pins(1'b1, 1'b1);
      u_host.cyc(8);
      chk(dout_oe === 1'b0, "deselect floats line");
      u_host.set_pins(1'b0, 1'b0);
      u_host.cyc(10);
      chk(dout_oe === 1'b1 && line === 1'b0, "both low drive low");
      $display("four_wire done");
   endtask : t_four_wire

   task automatic t_chain();
      start(16'h6D29, 1'b0, 1'b0, 1'b0);
      u_host.cyc(30);
      chk(chain === 1'b1 && dout_oe === 1'b1 && line === 1'b0, "chain msb");
      u_host.shift16(16'hC35A, got);
      chk(got === 16'h6D29, "chain own word");
      u_host.shift16(16'hFFFF, got);
      chk(got === 16'hC35A, "chain passes input");
      u_host.set_pins(1'b0, 1'b0);
      u_host.cyc(8);
      chk(dout_oe === 1'b1 && line === 1'b0, "chain parks low");
      $display("chain done");
   endtask : t_chain

   task automatic t_tied();
      u_host.cyc(8);
      u_host.set_pins(1'b1, 1'b1);
      u_host.cyc(30);
      chk(chain === 1'b1, "tied pins pick chain");
      $display("tied done");
   endtask : t_tied

   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim

   // Main sequence: twelve cycles of reset, then the scenarios in order.
   initial
   begin
      bad_count = 0;
      tests_run = 0;
      reset_n = 1'b0;
      sample = '0;
      repeat (12) @(posedge core_clk);
      #1 reset_n = 1'b1;
      u_host.cyc(8);
      t_three_wire();
      t_abort();
      t_four_wire();
      t_chain();
      t_tied();
      end_sim();
   end

   // Run needs about 370 core cycles; the limit is far above that.
   initial
   begin
      #200000;
      bad_count++;
      $display("BAD %0t watchdog expired", $time);
      end_sim();
   end

endmodule : tb_top

bind sar_readout sar_readout_properties #(.CONV_CYCLES(CONV_CYCLES)) u_props (
   .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
   .conversion_start_pin_i(conversion_start_pin_i),
   .serial_input_pin_i(serial_input_pin_i), .serial_output_pin_o(serial_output_pin_o),
   .serial_output_pin_oe_o(serial_output_pin_oe_o),
   .conversion_busy_o(conversion_busy_o), .powered_down_o(powered_down_o),
   .chain_mode_o(chain_mode_o)
);

`default_nettype wire
